// >>> shared/rtc_wd_pkg.sv
// constants, layouts and carrier types of the clock, alarm and watchdog memory
package rtc_wd_pkg;
  // ----------------------------------------
  // sizes
  // ----------------------------------------
  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;
  localparam int RAM_BYTES = 32768;
  localparam logic [ADDR_W-1:0] REG_COUNT = 15'h000e;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_MHZ = 200;
  localparam int TICK_PERIOD_US = 10000;
  localparam int TICK_CYCLES_DEFAULT = TICK_PERIOD_US * CLK_MHZ;
  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [3:0] REG_HUNDREDTHS = 4'h0;
  localparam logic [3:0] REG_SECONDS = 4'h1;
  localparam logic [3:0] REG_MINUTES = 4'h2;
  localparam logic [3:0] REG_ALM_MINUTES = 4'h3;
  localparam logic [3:0] REG_HOURS = 4'h4;
  localparam logic [3:0] REG_ALM_HOURS = 4'h5;
  localparam logic [3:0] REG_DAY = 4'h6;
  localparam logic [3:0] REG_ALM_DAY = 4'h7;
  localparam logic [3:0] REG_DATE = 4'h8;
  localparam logic [3:0] REG_MONTH = 4'h9;
  localparam logic [3:0] REG_YEAR = 4'ha;
  localparam logic [3:0] REG_COMMAND = 4'hb;
  localparam logic [3:0] REG_WD_FRAC = 4'hc;
  localparam logic [3:0] REG_WD_SEC = 4'hd;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int HOURS_12H_BIT = 6;
  localparam int HOURS_PM_BIT = 5;
  localparam int ALM_MASK_BIT = 7;
  localparam int CMD_WD_FLAG = 0;
  localparam int CMD_ALM_FLAG = 1;
  localparam int CMD_WD_IE = 2;
  localparam int CMD_ALM_IE = 3;
  localparam int CMD_STEER = 4;
  localparam int CMD_SQ_EN = 5;
  // ----------------------------------------
  // reset values and square wave threshold
  // ----------------------------------------
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_ONE = 8'h01;
  localparam logic [7:0] SQ_HALF = 8'h50;
  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } bus_pins_t;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_WRITE = 2'b01,
    BUS_READ = 2'b10
  } bus_state_t;
endpackage

// >>> logic/rtc_wd_core.sv
// byte-wide memory with calendar clock, alarm, watchdog and interrupt pins
`timescale 1ns/100ps
// Summary of operation
// - clock registers occupy the first 14 bytes
// - registers and ram use plain sram cycles
// - low supply blocks every write
// - hundredths through year counters with carries
// - month length and leap february honoured
// - selectable 12 or 24 hour, pm flag
// - watchdog period 0.01 to 99.99 seconds
// - weekly alarm match raises interrupt
// - interrupts run regardless of supply state
// - interrupt pins are active low open drain
// - software sets interrupt sources and square wave
// - watchdog timeout asserts its interrupt
// - read when ce, oe low, we high
// - write spans later fall to earlier rise
module rtc_wd_core
  import rtc_wd_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEFAULT
) (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic clk_en_in,
  input wire logic ce_n_in,
  input wire logic oe_n_in,
  input wire logic we_n_in,
  input wire logic [ADDR_W-1:0] addr_lines_in,
  input wire logic [DATA_W-1:0] data_lines_in,
  output logic [DATA_W-1:0] data_lines_out,
  output logic data_lines_oe_out,
  input wire logic supply_low_in,
  output logic power_fail_out_n_out,
  input wire logic irq_out_primary_n_in,
  output logic irq_out_primary_n_out,
  output logic irq_out_primary_n_oe_out,
  input wire logic irq_out_secondary_n_in,
  output logic irq_out_secondary_n_out,
  output logic irq_out_secondary_n_oe_out,
  output logic square_wave_out
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [8:0] bcd_step(logic [7:0] v, logic [7:0] lo, logic [7:0] hi);
    if (v >= hi) begin
      return {1'b1, lo};
    end
    if (v[3:0] >= 4'h9) begin
      return {1'b0, v[7:4] + 4'h1, 4'h0};
    end
    return {1'b0, v[7:4], v[3:0] + 4'h1};
  endfunction
  function automatic logic [7:0] month_days(logic [7:0] mon, logic [7:0] yr);
    logic leap;
    leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                 : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
    unique case (mon)
      8'h02: return leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: return 8'h30;
      default: return 8'h31;
    endcase
  endfunction
  function automatic logic [13:0] bcd_to_bin(logic [7:0] hi, logic [7:0] lo);
    return 14'(hi[7:4]) * 14'd1000 + 14'(hi[3:0]) * 14'd100
         + 14'(lo[7:4]) * 14'd10 + 14'(lo[3:0]);
  endfunction
  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  bus_pins_t pins_meta_ff, pins_ff, nxt_pins;
  logic pwr_meta_ff, pwr_low_ff;
  always_comb begin
    nxt_pins = '{ce_n: ce_n_in, oe_n: oe_n_in, we_n: we_n_in,
                 addr: addr_lines_in, data: data_lines_in};
  end
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      pins_meta_ff <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: '0, data: '0};
      pins_ff <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: '0, data: '0};
      pwr_meta_ff <= 1'b1;
      pwr_low_ff <= 1'b1;
    end else if (clk_en_in) begin
      pins_meta_ff <= nxt_pins;
      pins_ff <= pins_meta_ff;
      pwr_meta_ff <= supply_low_in;
      pwr_low_ff <= pwr_meta_ff;
    end
  end
  // ----------------------------------------
  // bus cycle tracking
  // ----------------------------------------
  bus_state_t state_ff, nxt_state;
  logic [ADDR_W-1:0] wr_addr_ff, nxt_wr_addr;
  logic [DATA_W-1:0] wr_data_ff, nxt_wr_data;
  logic write_active, read_active, wr_commit, reg_hit;
  always_comb begin
    write_active = !pins_ff.ce_n && !pins_ff.we_n;
    read_active = !pins_ff.ce_n && !pins_ff.oe_n && pins_ff.we_n;
    nxt_state = state_ff;
    nxt_wr_addr = wr_addr_ff;
    nxt_wr_data = wr_data_ff;
    wr_commit = 1'b0;
    unique case (state_ff)
      BUS_IDLE: begin
        if (write_active) begin
          nxt_state = BUS_WRITE;
        end else if (read_active) begin
          nxt_state = BUS_READ;
        end
      end
      BUS_WRITE: begin
        if (write_active) begin
          nxt_wr_addr = pins_ff.addr;
          nxt_wr_data = pins_ff.data;
        end else begin
          wr_commit = !pwr_low_ff;
          nxt_state = BUS_IDLE;
        end
      end
      BUS_READ: begin
        if (write_active) begin
          nxt_state = BUS_WRITE;
        end else if (!read_active) begin
          nxt_state = BUS_IDLE;
        end
      end
      default: nxt_state = BUS_IDLE;
    endcase
    reg_hit = wr_addr_ff < REG_COUNT;
  end
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      state_ff <= BUS_IDLE;
      wr_addr_ff <= '0;
      wr_data_ff <= '0;
    end else if (clk_en_in) begin
      state_ff <= nxt_state;
      wr_addr_ff <= nxt_wr_addr;
      wr_data_ff <= nxt_wr_data;
    end
  end
  // ----------------------------------------
  // user ram and read path
  // ----------------------------------------
  logic [DATA_W-1:0] ram_mem [0:RAM_BYTES-1];
  logic [DATA_W-1:0] regs_ff [0:13];
  logic [DATA_W-1:0] rd_data_ff, nxt_rd_data;
  always_comb begin
    nxt_rd_data = rd_data_ff;
    if (read_active) begin
      if (pins_ff.addr < REG_COUNT) begin
        nxt_rd_data = regs_ff[pins_ff.addr[3:0]];
      end else begin
        nxt_rd_data = ram_mem[pins_ff.addr];
      end
    end
  end
  always_ff @(posedge clk_sys_in) begin
    if (clk_en_in && wr_commit && !reg_hit) begin
      ram_mem[wr_addr_ff] <= wr_data_ff;
    end
  end
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      rd_data_ff <= '0;
    end else if (clk_en_in) begin
      rd_data_ff <= nxt_rd_data;
    end
  end
  // ----------------------------------------
  // 100 hz tick
  // ----------------------------------------
  logic [31:0] tick_cnt_ff, nxt_tick_cnt;
  logic tick;
  always_comb begin
    tick = tick_cnt_ff >= 32'(TICK_CYCLES - 1);
    nxt_tick_cnt = tick ? 32'h0000_0000 : tick_cnt_ff + 32'h0000_0001;
  end
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      tick_cnt_ff <= '0;
    end else if (clk_en_in) begin
      tick_cnt_ff <= nxt_tick_cnt;
    end
  end
  // ----------------------------------------
  // calendar, alarm, watchdog, command
  // ----------------------------------------
  logic [DATA_W-1:0] nxt_regs [0:13];
  logic [13:0] wd_cnt_ff, nxt_wd_cnt, wd_period;
  logic wd_load_ff, nxt_wd_load;
  logic [8:0] st;
  logic [7:0] hr, hv;
  logic carry, wd_fire, alm_fire, alm_min_ok, alm_hr_ok, alm_day_ok;
  always_comb begin
    for (int i = 0; i < 14; i++) begin
      nxt_regs[i] = regs_ff[i];
    end
    st = '0;
    hv = '0;
    carry = 1'b0;
    alm_fire = 1'b0;
    wd_fire = 1'b0;
    hr = regs_ff[REG_HOURS];
    if (tick) begin
      st = bcd_step(regs_ff[REG_HUNDREDTHS], 8'h00, 8'h99);
      nxt_regs[REG_HUNDREDTHS] = st[7:0];
      carry = st[8];
      if (carry) begin
        st = bcd_step(regs_ff[REG_SECONDS], 8'h00, 8'h59);
        nxt_regs[REG_SECONDS] = st[7:0];
        carry = st[8];
      end
      if (carry) begin
        st = bcd_step(regs_ff[REG_MINUTES], 8'h00, 8'h59);
        nxt_regs[REG_MINUTES] = st[7:0];
        carry = st[8];
        alm_fire = 1'b1;
      end
      if (carry) begin
        if (hr[HOURS_12H_BIT]) begin
          hv = {3'b000, hr[4:0]};
          if (hv == 8'h11) begin
            nxt_regs[REG_HOURS] = {hr[7:6], !hr[HOURS_PM_BIT], 5'h12};
            carry = hr[HOURS_PM_BIT];
          end else if (hv >= 8'h12) begin
            nxt_regs[REG_HOURS] = {hr[7:5], 5'h01};
            carry = 1'b0;
          end else begin
            st = bcd_step(hv, 8'h01, 8'h12);
            nxt_regs[REG_HOURS] = {hr[7:5], st[4:0]};
            carry = 1'b0;
          end
        end else begin
          st = bcd_step({2'b00, hr[5:0]}, 8'h00, 8'h23);
          nxt_regs[REG_HOURS] = {hr[7:6], st[5:0]};
          carry = st[8];
        end
      end
      if (carry) begin
        st = bcd_step(regs_ff[REG_DAY], 8'h01, 8'h07);
        nxt_regs[REG_DAY] = st[7:0];
        st = bcd_step(regs_ff[REG_DATE], 8'h01,
                      month_days(regs_ff[REG_MONTH], regs_ff[REG_YEAR]));
        nxt_regs[REG_DATE] = st[7:0];
        carry = st[8];
      end
      if (carry) begin
        st = bcd_step(regs_ff[REG_MONTH], 8'h01, 8'h12);
        nxt_regs[REG_MONTH] = st[7:0];
        carry = st[8];
      end
      if (carry) begin
        st = bcd_step(regs_ff[REG_YEAR], 8'h00, 8'h99);
        nxt_regs[REG_YEAR] = st[7:0];
      end
    end
    // weekly alarm checked once per new minute
    alm_min_ok = regs_ff[REG_ALM_MINUTES][ALM_MASK_BIT]
              || regs_ff[REG_ALM_MINUTES][6:0] == nxt_regs[REG_MINUTES][6:0];
    alm_hr_ok = regs_ff[REG_ALM_HOURS][ALM_MASK_BIT]
             || regs_ff[REG_ALM_HOURS][6:0] == nxt_regs[REG_HOURS][6:0];
    alm_day_ok = regs_ff[REG_ALM_DAY][ALM_MASK_BIT]
              || regs_ff[REG_ALM_DAY][6:0] == nxt_regs[REG_DAY][6:0];
    alm_fire = alm_fire && alm_min_ok && alm_hr_ok && alm_day_ok;
    // watchdog countdown in hundredths
    wd_period = bcd_to_bin(regs_ff[REG_WD_SEC], regs_ff[REG_WD_FRAC]);
    nxt_wd_cnt = wd_cnt_ff;
    nxt_wd_load = 1'b0;
    if (wd_load_ff) begin
      nxt_wd_cnt = wd_period;
    end else if (tick && wd_cnt_ff != 14'h0000) begin
      if (wd_cnt_ff == 14'h0001) begin
        wd_fire = 1'b1;
        nxt_wd_cnt = wd_period;
      end else begin
        nxt_wd_cnt = wd_cnt_ff - 14'h0001;
      end
    end
    // host write, flags keep set priority
    if (wr_commit && reg_hit) begin
      nxt_regs[wr_addr_ff[3:0]] = wr_data_ff;
      if (wr_addr_ff[3:0] == REG_WD_FRAC || wr_addr_ff[3:0] == REG_WD_SEC) begin
        nxt_wd_load = 1'b1;
      end
      if (wr_addr_ff[3:0] == REG_COMMAND) begin
        nxt_regs[REG_COMMAND][CMD_WD_FLAG] = regs_ff[REG_COMMAND][CMD_WD_FLAG]
                                          && wr_data_ff[CMD_WD_FLAG];
        nxt_regs[REG_COMMAND][CMD_ALM_FLAG] = regs_ff[REG_COMMAND][CMD_ALM_FLAG]
                                           && wr_data_ff[CMD_ALM_FLAG];
      end
    end
    if (wd_fire) begin
      nxt_regs[REG_COMMAND][CMD_WD_FLAG] = 1'b1;
    end
    if (alm_fire) begin
      nxt_regs[REG_COMMAND][CMD_ALM_FLAG] = 1'b1;
    end
  end
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < 14; i++) begin
        regs_ff[i] <= RST_ZERO;
      end
      regs_ff[REG_DAY] <= RST_ONE;
      regs_ff[REG_DATE] <= RST_ONE;
      regs_ff[REG_MONTH] <= RST_ONE;
      wd_cnt_ff <= '0;
      wd_load_ff <= 1'b0;
    end else if (clk_en_in) begin
      for (int i = 0; i < 14; i++) begin
        regs_ff[i] <= nxt_regs[i];
      end
      wd_cnt_ff <= nxt_wd_cnt;
      wd_load_ff <= nxt_wd_load;
    end
  end
  // ----------------------------------------
  // pins out
  // ----------------------------------------
  logic wd_irq, alm_irq;
  always_comb begin
    wd_irq = regs_ff[REG_COMMAND][CMD_WD_FLAG] && regs_ff[REG_COMMAND][CMD_WD_IE];
    alm_irq = regs_ff[REG_COMMAND][CMD_ALM_FLAG] && regs_ff[REG_COMMAND][CMD_ALM_IE];
    data_lines_out = rd_data_ff;
    data_lines_oe_out = state_ff == BUS_READ;
    power_fail_out_n_out = !pwr_low_ff;
    irq_out_primary_n_out = 1'b0;
    irq_out_secondary_n_out = 1'b0;
    irq_out_primary_n_oe_out = regs_ff[REG_COMMAND][CMD_STEER] ? alm_irq : wd_irq;
    irq_out_secondary_n_oe_out = regs_ff[REG_COMMAND][CMD_STEER] ? wd_irq : alm_irq;
    square_wave_out = regs_ff[REG_COMMAND][CMD_SQ_EN]
                   && regs_ff[REG_HUNDREDTHS] < SQ_HALF;
  end
endmodule

// >>> testbench/rtc_wd_core_asserts.sv
// pin-level checks of the clock, alarm and watchdog memory
`timescale 1ns/100ps
module rtc_wd_core_asserts
  import rtc_wd_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEFAULT
) (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic ce_n_in,
  input wire logic oe_n_in,
  input wire logic we_n_in,
  input wire logic [ADDR_W-1:0] addr_lines_in,
  input wire logic [DATA_W-1:0] data_lines_out,
  input wire logic data_lines_oe_out,
  input wire logic supply_low_in,
  input wire logic power_fail_out_n_out,
  input wire logic irq_out_primary_n_out,
  input wire logic irq_out_primary_n_oe_out,
  input wire logic irq_out_secondary_n_out,
  input wire logic irq_out_secondary_n_oe_out,
  input wire logic square_wave_out
);
  // ----
  // sequences
  // ----
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_read;
    !ce_n_in && !oe_n_in && we_n_in;
  endsequence
  sequence s_ram_read;
    !ce_n_in && !oe_n_in && we_n_in && addr_lines_in >= 15'h000e && $stable(addr_lines_in);
  endsequence
  sequence s_write;
    !ce_n_in && !we_n_in;
  endsequence
  a_read_drives: assert property (s_read [*5] |-> data_lines_oe_out)
    else $error("read cycle not driving data lines");
  a_idle_released: assert property (ce_n_in [*5] |-> !data_lines_oe_out)
    else $error("data lines driven while deselected");
  a_write_released: assert property (s_write [*4] |-> !data_lines_oe_out)
    else $error("data lines driven during write");
  a_ram_read_holds: assert property (s_ram_read [*6] |-> $stable(data_lines_out))
    else $error("read data moved under stable address");
  a_pf_low: assert property (supply_low_in [*6] |-> !power_fail_out_n_out)
    else $error("power fail not shown on low supply");
  a_pf_high: assert property (!supply_low_in [*6] |-> power_fail_out_n_out)
    else $error("power fail shown on good supply");
  a_primary_pulls_low: assert property (irq_out_primary_n_oe_out |-> !irq_out_primary_n_out)
    else $error("primary interrupt driven high");
  a_secondary_pulls_low: assert property (
    irq_out_secondary_n_oe_out |-> !irq_out_secondary_n_out)
    else $error("secondary interrupt driven high");
  a_reset_quiet: assert property (disable iff (1'b0) !rst_n_in |=> !data_lines_oe_out &&
    !irq_out_primary_n_oe_out && !irq_out_secondary_n_oe_out && !square_wave_out)
    else $error("outputs active in reset");
endmodule
bind rtc_wd_core rtc_wd_core_asserts #(.TICK_CYCLES(TICK_CYCLES)) i_rtc_wd_core_asserts (
  .clk_sys_in(clk_sys_in),
  .rst_n_in(rst_n_in),
  .ce_n_in(ce_n_in),
  .oe_n_in(oe_n_in),
  .we_n_in(we_n_in),
  .addr_lines_in(addr_lines_in),
  .data_lines_out(data_lines_out),
  .data_lines_oe_out(data_lines_oe_out),
  .supply_low_in(supply_low_in),
  .power_fail_out_n_out(power_fail_out_n_out),
  .irq_out_primary_n_out(irq_out_primary_n_out),
  .irq_out_primary_n_oe_out(irq_out_primary_n_oe_out),
  .irq_out_secondary_n_out(irq_out_secondary_n_out),
  .irq_out_secondary_n_oe_out(irq_out_secondary_n_oe_out),
  .square_wave_out(square_wave_out)
);

// >>> testbench/host_bus_model.sv
// host processor model on the byte-wide sram bus
`timescale 1ns/100ps
module host_bus_model
  import rtc_wd_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic [DATA_W-1:0] dq_in,
  input wire logic dq_oe_in,
  output bus_pins_t pins_out
);
  initial pins_out = '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: '0, data: '0};
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk_sys_in);
    pins_out.addr <= a;
    pins_out.data <= d;
    pins_out.ce_n <= 1'b0;
    pins_out.we_n <= 1'b0;
    repeat (4) @(posedge clk_sys_in);
    pins_out.ce_n <= 1'b1;
    pins_out.we_n <= 1'b1;
    @(posedge clk_sys_in);
    pins_out.data <= ~d;
    repeat (5) @(posedge clk_sys_in);
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d, output bit ok);
    int n;
    ok = 1'b0;
    d = '0;
    @(posedge clk_sys_in);
    pins_out.addr <= a;
    pins_out.ce_n <= 1'b0;
    pins_out.oe_n <= 1'b0;
    for (n = 0; n < 20 && !ok; n++) begin
      @(posedge clk_sys_in);
      if (dq_oe_in === 1'b1) begin
        d = dq_in;
        ok = 1'b1;
      end
    end
    if (ok) begin
      repeat (3) @(posedge clk_sys_in);
    end
    pins_out.ce_n <= 1'b1;
    pins_out.oe_n <= 1'b1;
    repeat (5) @(posedge clk_sys_in);
  endtask
endmodule

// >>> testbench/tb_rtc_wd_core.sv
// self-checking bench of the clock, alarm and watchdog memory
`timescale 1ns/100ps
module tb_rtc_wd_core;
  import rtc_wd_pkg::*;
  localparam int unsigned TICKS = 20;
  logic clk_sys_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic supply_low_in = 1'b0;
  logic clk_en = 1'b1;
  bus_pins_t pins;
  logic [7:0] dq_dev;
  logic [7:0] dq;
  logic dq_oe, pf_n, a_oe, b_oe, a_drv, b_drv, irq_a, irq_b, sq;
  int err_total = 0;
  int checks_done = 0;
  logic [7:0] yr[3] = '{8'h01, 8'h04, 8'h01};
  logic [7:0] mo[3] = '{8'h02, 8'h02, 8'h04};
  logic [7:0] dt[3] = '{8'h28, 8'h28, 8'h30};
  logic [7:0] hr[3] = '{8'h23, 8'h71, 8'h23};
  logic [7:0] emo[3] = '{8'h03, 8'h02, 8'h05};
  logic [7:0] edt[3] = '{8'h01, 8'h29, 8'h01};
  logic [7:0] ehr[3] = '{8'h00, 8'h52, 8'h00};
  assign dq = dq_oe ? dq_dev : pins.data;
  assign irq_a = a_oe ? a_drv : 1'b1;
  assign irq_b = b_oe ? b_drv : 1'b1;
  initial forever #2.5 clk_sys_in = ~clk_sys_in;
  host_bus_model i_host_bus_model (.clk_sys_in(clk_sys_in), .dq_in(dq), .dq_oe_in(dq_oe),
    .pins_out(pins));
  rtc_wd_core #(.TICK_CYCLES(TICKS)) i_rtc_wd_core (.clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in), .clk_en_in(clk_en), .ce_n_in(pins.ce_n), .oe_n_in(pins.oe_n),
    .we_n_in(pins.we_n), .addr_lines_in(pins.addr), .data_lines_in(dq),
    .data_lines_out(dq_dev), .data_lines_oe_out(dq_oe), .supply_low_in(supply_low_in),
    .power_fail_out_n_out(pf_n), .irq_out_primary_n_in(irq_a), .irq_out_primary_n_out(a_drv),
    .irq_out_primary_n_oe_out(a_oe), .irq_out_secondary_n_in(irq_b),
    .irq_out_secondary_n_out(b_drv), .irq_out_secondary_n_oe_out(b_oe),
    .square_wave_out(sq));
  // ----
  // shared tasks
  // ----
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic logic [ADDR_W-1:0] ra(input logic [3:0] r);
    return {11'h000, r};
  endfunction
  task automatic wr(input logic [3:0] r, input logic [7:0] d);
    i_host_bus_model.wr(ra(r), d);
  endtask
  task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [7:0] exp, input string what);
    logic [7:0] d;
    bit ok;
    i_host_bus_model.rd(a, d, ok);
    if (!ok) begin
      err_total++;
      $display("ERROR %s expected read seen none", what);
      conclude();
    end else begin
      chk(what, exp, d);
    end
  endtask
  task automatic wait_pin(input bit sel, input logic exp, input string what);
    int n;
    for (n = 0; n < 400; n++) begin
      @(posedge clk_sys_in);
      if ((sel ? irq_b : irq_a) === exp) break;
    end
    chk(what, {7'h00, exp}, {7'h00, sel ? irq_b : irq_a});
    if (n == 400) conclude();
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_map();
    rdchk(ra(REG_DAY), RST_ONE, "day reset");
    rdchk(ra(REG_MONTH), RST_ONE, "month reset");
    rdchk(ra(REG_COMMAND), RST_ZERO, "command reset");
    i_host_bus_model.wr(15'h000e, 8'ha5);
    i_host_bus_model.wr(15'h7fff, 8'h3c);
    wr(REG_YEAR, 8'h99);
    rdchk(15'h000e, 8'ha5, "ram low");
    rdchk(15'h7fff, 8'h3c, "ram top");
    rdchk(ra(REG_YEAR), 8'h99, "year");
    $display("test map done");
  endtask
  task automatic t_low_supply();
    supply_low_in <= 1'b1;
    repeat (6) @(posedge clk_sys_in);
    chk("power fail", 8'h00, {7'h00, pf_n});
    i_host_bus_model.wr(15'h000e, 8'h5a);
    supply_low_in <= 1'b0;
    repeat (6) @(posedge clk_sys_in);
    chk("power good", 8'h01, {7'h00, pf_n});
    rdchk(15'h000e, 8'ha5, "blocked write");
    $display("test low supply done");
  endtask
  task automatic t_calendar();
    int i;
    for (i = 0; i < 3; i++) begin
      wr(REG_HUNDREDTHS, 8'h00);
      wr(REG_YEAR, yr[i]);
      wr(REG_MONTH, mo[i]);
      wr(REG_DATE, dt[i]);
      wr(REG_HOURS, hr[i]);
      wr(REG_MINUTES, 8'h59);
      wr(REG_SECONDS, 8'h59);
      wr(REG_HUNDREDTHS, 8'h99);
      repeat (2 * TICKS) @(posedge clk_sys_in);
      rdchk(ra(REG_HOURS), ehr[i], "hours");
      rdchk(ra(REG_DATE), edt[i], "date");
      rdchk(ra(REG_MONTH), emo[i], "month");
      rdchk(ra(REG_DAY), 8'(i + 2), "day");
    end
    $display("test calendar done");
  endtask
  task automatic t_watchdog();
    int s;
    for (s = 0; s < 2; s++) begin
      wr(REG_COMMAND, s == 1 ? 8'h14 : 8'h04);
      wr(REG_WD_SEC, 8'h00);
      wr(REG_WD_FRAC, 8'h02);
      supply_low_in <= 1'b1;
      wait_pin(s[0], 1'b0, "watchdog pin");
      chk("idle pin", 8'h01, {7'h00, s == 1 ? irq_a : irq_b});
      supply_low_in <= 1'b0;
      repeat (6) @(posedge clk_sys_in);
      wr(REG_WD_FRAC, 8'h00);
      wr(REG_COMMAND, 8'h00);
      wait_pin(s[0], 1'b1, "watchdog release");
    end
    $display("test watchdog done");
  endtask
  task automatic t_alarm();
    wr(REG_ALM_MINUTES, 8'h01);
    wr(REG_ALM_HOURS, 8'h80);
    wr(REG_ALM_DAY, 8'h80);
    wr(REG_COMMAND, 8'h08);
    wr(REG_HUNDREDTHS, 8'h00);
    wr(REG_MINUTES, 8'h00);
    wr(REG_SECONDS, 8'h59);
    wr(REG_HUNDREDTHS, 8'h99);
    wait_pin(1'b1, 1'b0, "alarm pin");
    chk("primary idle", 8'h01, {7'h00, irq_a});
    wr(REG_COMMAND, 8'h00);
    wait_pin(1'b1, 1'b1, "alarm release");
    $display("test alarm done");
  endtask
  task automatic t_square();
    wr(REG_COMMAND, 8'h20);
    wr(REG_HUNDREDTHS, 8'h00);
    chk("square high", 8'h01, {7'h00, sq});
    clk_en <= 1'b0;
    repeat (60 * TICKS) @(posedge clk_sys_in);
    clk_en <= 1'b1;
    @(posedge clk_sys_in);
    chk("square frozen", 8'h01, {7'h00, sq});
    wr(REG_HUNDREDTHS, 8'h60);
    chk("square low", 8'h00, {7'h00, sq});
    $display("test square done");
  endtask
  initial begin
    repeat (16) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    repeat (4) @(posedge clk_sys_in);
    t_map();
    t_low_supply();
    t_calendar();
    t_watchdog();
    t_alarm();
    t_square();
    conclude();
  end
endmodule
